// file: rtl/vow_voice_top.sv
// Three-voice tone generator core: register bus, oscillators, envelopes.
// Assumes the host bus is synchronous to clk_in and drives it cleanly.
//
// Function
// RULE_01 - Five address lines select one of 29 byte registers; voice one 0-6.
// RULE_02 - Pitch increment is 16 bits, low byte register 0, high byte 1.
// RULE_03 - Output frequency is increment times clock over 16777216.
// RULE_04 - Each clock adds the increment to a wrapping 24-bit phase accumulator.
// RULE_05 - Duty word is 12 bits; top four bits of its high byte ignored.
// RULE_06 - Duty 0 or 4095 gives a constant level, 2048 a square.
// RULE_07 - Gate rising starts attack-decay-sustain, gate falling starts release.
// RULE_08 - Hard lock restarts the phase on the source oscillator's fundamental.
// RULE_09 - Hard lock acts only while the source increment is nonzero.
// RULE_10 - Product mix replaces triangle with ring combination with the source.
// RULE_11 - Host selects triangle and a nonzero source increment for ring mix.
// RULE_12 - Hold bit zeroes and holds oscillator, resets noise, pins pulse high.
// RULE_13 - Control bit 4 selects the triangle waveform.
// RULE_14 - Control bit 5 selects the sawtooth waveform.
// RULE_15 - Control bit 6 selects the pulse waveform with programmed duty.
// RULE_16 - Control bit 7 selects noise that changes at oscillator rate.
// RULE_17 - Several selected waveforms combine by bitwise AND, not by sum.
// RULE_18 - Noise mixed with others may lock; hold or reset frees it.
// RULE_19 - Amplitude comes from the envelope only; no selection means silence.
// RULE_20 - Pulse is high while the top twelve phase bits reach duty.
// RULE_21 - Voice two locks to oscillator one, voice three to two.
// RULE_22 - Voice registers are write-only; readable registers are read-only.
// RULE_23 - Gate changes mid-envelope restart from the current amplitude.
`timescale 1ns/10ps
module vow_voice_top (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic chip_select_n_in,
    input wire logic read_write_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic [7:0] reg_data_in,
    output logic [7:0] reg_data_out,
    output logic [2:0][19:0] voice_level_out
);
    // ****************************************************************
    // Types and decoding helpers
    // ****************************************************************
    typedef struct packed {
        vow_pkg::vow_voice_regs_t [2:0] regs;
        vow_pkg::vow_env_t [2:0] env;
        logic [2:0][19:0] level;
        logic [7:0] rd_data;
    } vow_top_state_t;

    // Voice that owns an address, or 3 when the address is not a voice register.
    function automatic logic [1:0] voice_of(input logic [4:0] addr);
        if (addr < 5'd7) begin
            voice_of = 2'd0;
        end else if (addr < 5'd14) begin
            voice_of = 2'd1;
        end else if (addr < 5'd21) begin
            voice_of = 2'd2;
        end else begin
            voice_of = 2'd3;
        end
    endfunction

    // Register index within its voice group.
    function automatic logic [2:0] field_of(input logic [4:0] addr);
        logic [4:0] rem;
        rem = addr;
        if (addr >= 5'd14) begin
            rem = addr - 5'd14;
        end else if (addr >= 5'd7) begin
            rem = addr - 5'd7;
        end
        field_of = rem[2:0];
    endfunction

    // Cycles per envelope step; falling phases are three times slower.
    function automatic logic [27:0] env_period(input logic [3:0] rate, input logic fall);
        logic [27:0] base;
        base = 28'(vow_pkg::ENV_STEP_CYC) << rate;
        env_period = fall ? 28'(base * vow_pkg::ENV_FALL_FACTOR) : base;
    endfunction

    // ****************************************************************
    // Oscillators
    // ****************************************************************
    vow_top_state_t st_reg;
    vow_top_state_t st_next;
    logic [2:0] osc_msb;
    logic [2:0] osc_rise;
    logic [2:0][11:0] osc_wave;
    logic bus_write;
    logic bus_read;

    // Each voice takes the previous oscillator as source, voice one takes three.
    generate
        for (genvar v = 0; v < vow_pkg::NUM_VOICES; v++) begin : g_osc
            localparam int SRC = (v + 2) % 3; // see RULE_21
            vow_osc u_osc (
                .clk_in(clk_in),
                .rst_n_in(rst_n_in),
                .pitch_in(st_reg.regs[v].pitch),
                .duty_in(st_reg.regs[v].duty),
                .ctrl_in(st_reg.regs[v].ctrl),
                .src_msb_in(osc_msb[SRC]),
                .src_msb_rise_in(osc_rise[SRC]),
                .src_nonzero_in(st_reg.regs[SRC].pitch != 16'h0000), // see RULE_09
                .msb_out(osc_msb[v]),
                .msb_rise_out(osc_rise[v]),
                .wave_out(osc_wave[v])
            );
        end
    endgenerate

    // ****************************************************************
    // Register bus, envelopes and output scaling
    // ****************************************************************
    // Bus strobes; read_write high means a read as on the host side.
    assign bus_write = !chip_select_n_in && !read_write_in;
    assign bus_read = !chip_select_n_in && read_write_in;

    always_comb begin
        st_next = st_reg;
        // Host writes land in the owning voice; writes above the voice groups are accepted and dropped.
        for (int v = 0; v < vow_pkg::NUM_VOICES; v++) begin
            if (bus_write && voice_of(reg_addr_in) == 2'(v)) begin // see RULE_01
                unique case (field_of(reg_addr_in))
                    vow_pkg::REG_PITCH_LO: begin
                        st_next.regs[v].pitch[7:0] = reg_data_in; // see RULE_02
                    end
                    vow_pkg::REG_PITCH_HI: begin
                        st_next.regs[v].pitch[15:8] = reg_data_in; // see RULE_02
                    end
                    vow_pkg::REG_DUTY_LO: begin
                        st_next.regs[v].duty[7:0] = reg_data_in; // see RULE_05
                    end
                    vow_pkg::REG_DUTY_HI: begin
                        st_next.regs[v].duty[11:8] = reg_data_in[3:0]; // see RULE_05
                    end
                    vow_pkg::REG_CONTROL: begin
                        st_next.regs[v].ctrl = reg_data_in;
                    end
                    vow_pkg::REG_ATK_DCY: begin
                        st_next.regs[v].atk_dcy = reg_data_in;
                    end
                    vow_pkg::REG_SUS_REL: begin
                        st_next.regs[v].sus_rel = reg_data_in;
                    end
                    default: begin
                        st_next.regs[v] = st_reg.regs[v];
                    end
                endcase
            end
        end

        // Envelope per voice follows the gate bit of the stored control register.
        for (int v = 0; v < vow_pkg::NUM_VOICES; v++) begin
            st_next.env[v].gate_prev = st_reg.regs[v].ctrl[vow_pkg::CTRL_GATE];
            if (st_reg.regs[v].ctrl[vow_pkg::CTRL_GATE] && !st_reg.env[v].gate_prev) begin
                // The level is kept so a retrigger climbs from where it was.
                st_next.env[v].phase = vow_pkg::VOW_ENV_ATTACK; // see RULE_07 RULE_23
                st_next.env[v].count = 28'h0000000;
            end else if (!st_reg.regs[v].ctrl[vow_pkg::CTRL_GATE] && st_reg.env[v].gate_prev) begin
                st_next.env[v].phase = vow_pkg::VOW_ENV_RELEASE; // see RULE_07 RULE_23
                st_next.env[v].count = 28'h0000000;
            end else begin
                st_next.env[v].count = st_reg.env[v].count + 28'h0000001;
                unique case (st_reg.env[v].phase)
                    vow_pkg::VOW_ENV_ATTACK: begin
                        if (st_reg.env[v].count + 28'h0000001
                                >= env_period(st_reg.regs[v].atk_dcy[7:4], 1'b0)) begin
                            st_next.env[v].count = 28'h0000000;
                            if (st_reg.env[v].level == vow_pkg::ENV_PEAK) begin
                                st_next.env[v].phase = vow_pkg::VOW_ENV_DECAY;
                            end else begin
                                st_next.env[v].level = st_reg.env[v].level + 8'h01;
                            end
                        end
                    end
                    vow_pkg::VOW_ENV_DECAY: begin
                        if (st_reg.env[v].count + 28'h0000001
                                >= env_period(st_reg.regs[v].atk_dcy[3:0], 1'b1)) begin
                            st_next.env[v].count = 28'h0000000;
                            // Sustain nibble doubled gives sixteen even steps.
                            if (st_reg.env[v].level > {st_reg.regs[v].sus_rel[7:4],
                                    st_reg.regs[v].sus_rel[7:4]}) begin
                                st_next.env[v].level = st_reg.env[v].level - 8'h01;
                            end
                        end
                    end
                    vow_pkg::VOW_ENV_RELEASE: begin
                        if (st_reg.env[v].count + 28'h0000001
                                >= env_period(st_reg.regs[v].sus_rel[3:0], 1'b1)) begin
                            st_next.env[v].count = 28'h0000000;
                            if (st_reg.env[v].level != 8'h00) begin
                                st_next.env[v].level = st_reg.env[v].level - 8'h01;
                            end
                        end
                    end
                    default: begin
                        st_next.env[v].phase = vow_pkg::VOW_ENV_RELEASE;
                    end
                endcase
            end
            // Amplitude is wave times envelope level only.
            st_next.level[v] = osc_wave[v] * st_reg.env[v].level; // see RULE_19
        end

        // Voice registers read as zero; only the third voice's monitors answer.
        st_next.rd_data = 8'h00; // see RULE_22
        if (bus_read && reg_addr_in == vow_pkg::REG_OSC3_READ) begin
            st_next.rd_data = osc_wave[2][11:4];
        end else if (bus_read && reg_addr_in == vow_pkg::REG_ENV3_READ) begin
            st_next.rd_data = st_reg.env[2].level;
        end
    end

    // State register; the reset also frees a locked noise source.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
            for (int v = 0; v < vow_pkg::NUM_VOICES; v++) begin
                st_reg.env[v].phase <= vow_pkg::VOW_ENV_RELEASE;
            end
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_data_out = st_reg.rd_data;
    assign voice_level_out = st_reg.level;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_pitch_low;
        @(posedge clk_in) disable iff (!rst_n_in)
        bus_write && reg_addr_in == 5'h00 |=> st_reg.regs[0].pitch[7:0] == $past(reg_data_in);
    endproperty
    a_pitch_low: assert property (p_pitch_low) else $error("pitch low not stored"); // see RULE_02

    property p_pitch_v2_high;
        @(posedge clk_in) disable iff (!rst_n_in)
        bus_write && reg_addr_in == 5'h08 |=> st_reg.regs[1].pitch[15:8] == $past(reg_data_in);
    endproperty
    a_pitch_v2_high: assert property (p_pitch_v2_high) else $error("decode wrong"); // see RULE_01

    property p_duty_high;
        @(posedge clk_in) disable iff (!rst_n_in)
        bus_write && reg_addr_in == 5'h03 |=> st_reg.regs[0].duty[11:8] == $past(reg_data_in[3:0]);
    endproperty
    a_duty_high: assert property (p_duty_high) else $error("duty high wrong"); // see RULE_05

    property p_gate_rise;
        @(posedge clk_in) disable iff (!rst_n_in)
        st_reg.regs[0].ctrl[0] && !st_reg.env[0].gate_prev |=>
            st_reg.env[0].phase == vow_pkg::VOW_ENV_ATTACK
            && st_reg.env[0].level == $past(st_reg.env[0].level);
    endproperty
    a_gate_rise: assert property (p_gate_rise) else $error("attack not started"); // see RULE_07

    property p_gate_fall;
        @(posedge clk_in) disable iff (!rst_n_in)
        !st_reg.regs[0].ctrl[0] && st_reg.env[0].gate_prev |=>
            st_reg.env[0].phase == vow_pkg::VOW_ENV_RELEASE
            && st_reg.env[0].level == $past(st_reg.env[0].level);
    endproperty
    a_gate_fall: assert property (p_gate_fall) else $error("release not started"); // see RULE_23

    property p_voice_reads_zero;
        @(posedge clk_in) disable iff (!rst_n_in)
        bus_read && reg_addr_in < 5'h15 |=> reg_data_out == 8'h00;
    endproperty
    a_voice_reads_zero: assert property (p_voice_reads_zero) // see RULE_22
        else $error("voice reg read");
endmodule

// file: include/vow_pkg.sv
// Constants and types shared by the voice oscillator block.
// Assumes one clock at 125 MHz and a synchronous, active-low reset.
// ****************************************************************
// Package
// ****************************************************************
package vow_pkg;
    localparam int NUM_VOICES = 3;
    localparam int REGS_PER_VOICE = 7;
    localparam logic [4:0] REG_LAST = 5'h1C;
    localparam logic [4:0] REG_OSC3_READ = 5'h1B;
    localparam logic [4:0] REG_ENV3_READ = 5'h1C;
    // Offsets of the voice registers within one voice's group of seven.
    localparam logic [2:0] REG_PITCH_LO = 3'h0;
    localparam logic [2:0] REG_PITCH_HI = 3'h1;
    localparam logic [2:0] REG_DUTY_LO = 3'h2;
    localparam logic [2:0] REG_DUTY_HI = 3'h3;
    localparam logic [2:0] REG_CONTROL = 3'h4;
    localparam logic [2:0] REG_ATK_DCY = 3'h5;
    localparam logic [2:0] REG_SUS_REL = 3'h6;
    // Bit positions in the voice control register.
    localparam int CTRL_GATE = 0;
    localparam int CTRL_LOCK = 1;
    localparam int CTRL_MIX = 2;
    localparam int CTRL_HOLD = 3;
    localparam int CTRL_TRI = 4;
    localparam int CTRL_SAW = 5;
    localparam int CTRL_PULSE = 6;
    localparam int CTRL_NOISE = 7;
    // Oscillator layout and values after reset.
    localparam int ACC_W = 24;
    localparam int WAVE_W = 12;
    localparam int NOISE_W = 23;
    localparam logic [23:0] ACC_RESET = 24'h000000;
    localparam logic [22:0] NOISE_SEED = 23'h7FFFFF;
    localparam logic [11:0] DUTY_MAX = 12'hFFF;
    localparam int NOISE_TAP [8] = '{0, 2, 5, 9, 11, 14, 18, 20};
    // Envelope step timing: the fastest attack climbs 255 steps in 2 ms.
    localparam int CLK_PERIOD_NS = 8;
    localparam int ENV_STEP_NS = 7843;
    localparam int ENV_STEP_CYC = ENV_STEP_NS / CLK_PERIOD_NS;
    localparam int ENV_FALL_FACTOR = 3;
    localparam logic [7:0] ENV_PEAK = 8'hFF;

    typedef enum logic [1:0] {
        VOW_ENV_ATTACK,
        VOW_ENV_DECAY,
        VOW_ENV_RELEASE
    } vow_env_phase_t;

    typedef struct packed {
        logic [15:0] pitch;
        logic [11:0] duty;
        logic [7:0] ctrl;
        logic [7:0] atk_dcy;
        logic [7:0] sus_rel;
    } vow_voice_regs_t;

    typedef struct packed {
        vow_env_phase_t phase;
        logic [7:0] level;
        logic [27:0] count;
        logic gate_prev;
    } vow_env_t;

    typedef struct packed {
        logic [23:0] acc;
        logic [22:0] lfsr;
        logic msb_prev;
        logic b19_prev;
        logic [11:0] wave;
    } vow_osc_state_t;
endpackage

// file: rtl/vow_osc.sv
// One tone oscillator: phase accumulator, four waveforms and noise source.
// Assumes its register values and the source oscillator share clk_in.
`timescale 1ns/10ps
module vow_osc (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] pitch_in,
    input wire logic [11:0] duty_in,
    input wire logic [7:0] ctrl_in,
    input wire logic src_msb_in,
    input wire logic src_msb_rise_in,
    input wire logic src_nonzero_in,
    output logic msb_out,
    output logic msb_rise_out,
    output logic [11:0] wave_out
);
    // ****************************************************************
    // State and next state
    // ****************************************************************
    vow_pkg::vow_osc_state_t st_reg;
    vow_pkg::vow_osc_state_t st_next;
    logic lock_hit;
    logic [11:0] tri_w;
    logic [11:0] saw_w;
    logic [11:0] pulse_w;
    logic [11:0] noise_w;
    logic [11:0] mix_w;

    // Waveform shaping and accumulator advance.
    always_comb begin
        st_next = st_reg;
        // Lock fires on the source's top-bit rise, only while its increment is nonzero.
        lock_hit = ctrl_in[vow_pkg::CTRL_LOCK] && src_msb_rise_in
            && src_nonzero_in; // see RULE_08 RULE_09
        // Ring mixing flips the triangle fold with the source's top bit.
        tri_w = {st_reg.acc[22:12] // see RULE_10
            ^ {11{st_reg.acc[23] ^ (ctrl_in[vow_pkg::CTRL_MIX] & src_msb_in)}}, 1'b0};
        saw_w = st_reg.acc[23:12]; // see RULE_04
        // The full-scale duty is treated as never high so both ends stay constant.
        if (ctrl_in[vow_pkg::CTRL_HOLD]) begin
            pulse_w = 12'hFFF; // see RULE_12
        end else if (duty_in != vow_pkg::DUTY_MAX && st_reg.acc[23:12] >= duty_in) begin
            pulse_w = 12'hFFF; // see RULE_20 RULE_06
        end else begin
            pulse_w = 12'h000;
        end
        noise_w = 12'h000;
        for (int k = 0; k < 8; k++) begin
            noise_w[k + 4] = st_reg.lfsr[vow_pkg::NOISE_TAP[k]]; // see RULE_16
        end
        // Selected waveforms are ANDed; nothing selected gives silence.
        mix_w = 12'hFFF;
        if (ctrl_in[vow_pkg::CTRL_TRI]) mix_w = mix_w & tri_w; // see RULE_13
        if (ctrl_in[vow_pkg::CTRL_SAW]) mix_w = mix_w & saw_w; // see RULE_14
        if (ctrl_in[vow_pkg::CTRL_PULSE]) mix_w = mix_w & pulse_w; // see RULE_15
        if (ctrl_in[vow_pkg::CTRL_NOISE]) mix_w = mix_w & noise_w;
        st_next.wave = (|ctrl_in[7:4]) ? mix_w : 12'h000; // see RULE_17 RULE_19
        st_next.msb_prev = st_reg.acc[23];
        st_next.b19_prev = st_reg.acc[19];
        if (ctrl_in[vow_pkg::CTRL_HOLD]) begin
            st_next.acc = vow_pkg::ACC_RESET; // see RULE_12
            st_next.lfsr = vow_pkg::NOISE_SEED; // see RULE_18
        end else begin
            // A wrapping 24-bit add gives an output rate of increment times clock over 2^24.
            st_next.acc = lock_hit ? vow_pkg::ACC_RESET
                : st_reg.acc + {8'h00, pitch_in}; // see RULE_03 RULE_04
            if (st_reg.acc[19] && !st_reg.b19_prev) begin
                st_next.lfsr = {st_reg.lfsr[21:0], st_reg.lfsr[22] ^ st_reg.lfsr[17]};
            end
            // Mixing noise with others writes the AND back and can lock it.
            if (ctrl_in[vow_pkg::CTRL_NOISE] && |ctrl_in[6:4]) begin
                for (int k = 0; k < 8; k++) begin
                    st_next.lfsr[vow_pkg::NOISE_TAP[k]] = st_next.lfsr[vow_pkg::NOISE_TAP[k]]
                        & mix_w[k + 4]; // see RULE_18
                end
            end
        end
    end

    // State register.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_reg <= '{acc: vow_pkg::ACC_RESET, lfsr: vow_pkg::NOISE_SEED, msb_prev: 1'b0,
                b19_prev: 1'b0, wave: 12'h000};
        end else begin
            st_reg <= st_next;
        end
    end

    assign msb_out = st_reg.acc[23];
    assign msb_rise_out = st_reg.acc[23] & ~st_reg.msb_prev;
    assign wave_out = st_reg.wave;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_acc_step;
        @(posedge clk_in) disable iff (!rst_n_in)
        !ctrl_in[vow_pkg::CTRL_HOLD] && !lock_hit |=>
            st_reg.acc == 24'($past(st_reg.acc) + {8'h00, $past(pitch_in)});
    endproperty
    a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong"); // see RULE_04

    property p_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        ctrl_in[vow_pkg::CTRL_HOLD] |=> st_reg.acc == 24'h000000 && &st_reg.lfsr;
    endproperty
    a_hold: assert property (p_hold) else $error("hold did not clear oscillator"); // see RULE_12

    property p_silent;
        @(posedge clk_in) disable iff (!rst_n_in)
        ctrl_in[7:4] == 4'h0 |=> wave_out == 12'h000;
    endproperty
    a_silent: assert property (p_silent) else $error("output not silent"); // see RULE_19

    property p_saw_and_pulse;
        @(posedge clk_in) disable iff (!rst_n_in)
        ctrl_in[7:4] == 4'h6 |=> wave_out == ($past(saw_w) & $past(pulse_w));
    endproperty
    a_saw_and_pulse: assert property (p_saw_and_pulse) else $error("mix not AND"); // see RULE_17

    property p_lock;
        @(posedge clk_in) disable iff (!rst_n_in)
        ctrl_in[vow_pkg::CTRL_LOCK] && src_msb_rise_in && src_nonzero_in
            && !ctrl_in[vow_pkg::CTRL_HOLD] |=> st_reg.acc == 24'h000000;
    endproperty
    a_lock: assert property (p_lock) else $error("hard lock missed"); // see RULE_08
endmodule

// file: tb/vow_host_model.sv
// Host model: drives the byte-wide register bus of the voice block.
// Assumes callers enter its task just after a falling clk_in edge.
`timescale 1ns/10ps
// ****************************************************************
// Host bus model
// ****************************************************************
module vow_host_model (
    input wire logic clk_in,
    output logic chip_select_n_out,
    output logic read_write_out,
    output logic [4:0] reg_addr_out,
    output logic [7:0] reg_data_out,
    input wire logic [7:0] reg_rdata_in
);
    // Start deselected so nothing is taken while reset is held.
    initial begin
        chip_select_n_out = 1'b1;
        read_write_out = 1'b1;
        reg_addr_out = 5'h00;
        reg_data_out = 8'h00;
    end
    // One bus cycle; address and data are inverted on release so stale values never pass as held.
    task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(negedge clk_in);
        chip_select_n_out = 1'b0;
        read_write_out = rd;
        reg_addr_out = a;
        reg_data_out = d;
        @(posedge clk_in);
        @(negedge clk_in);
        q = reg_rdata_in;
        chip_select_n_out = 1'b1;
        reg_addr_out = ~a;
        reg_data_out = ~d;
    endtask
endmodule

// file: tb/voice_oscillator_waveform_bench.sv
// Self-checking bench for the voice block, using voice three's readback byte.
// Assumes the host model answers reads half a cycle after the read edge.
`timescale 1ns/10ps
// ****************************************************************
// Bench top
// ****************************************************************
module voice_oscillator_waveform_bench;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cs_n, rw;
    logic [4:0] addr;
    logic [7:0] wdata, rdata, q, r1, e1;
    logic [2:0][19:0] level;
    logic [15:0] p;
    logic [11:0] duty [3] = '{12'h000, 12'hFFF, 12'h800};
    logic [7:0] hctl [6] = '{8'h48, 8'h28, 8'h68, 8'h88, 8'hC8, 8'h18};
    logic [7:0] hexp [6] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
    int failures = 0;
    int checks_done = 0;
    // Free-running clock at 125 MHz.
    always #4 clk_in = ~clk_in;
    vow_host_model host_u (.clk_in(clk_in), .chip_select_n_out(cs_n), .read_write_out(rw),
        .reg_addr_out(addr), .reg_data_out(wdata), .reg_rdata_in(rdata));
    vow_voice_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .chip_select_n_in(cs_n),
        .read_write_in(rw), .reg_addr_in(addr), .reg_data_in(wdata),
        .reg_data_out(rdata), .voice_level_out(level));
    // Pulse byte expected for a phase; the top duty value is a constant low.
    function automatic logic [7:0] exp_pulse(input logic [11:0] d, input logic [11:0] ph);
        return (d != 12'hFFF && ph >= d) ? 8'hFF : 8'h00;
    endfunction
    // Top byte advance of a sawtooth after k clocks at increment inc.
    function automatic logic [7:0] saw_step(input logic [15:0] inc, input int k);
        return 8'((32'(inc) * k) >> 16);
    endfunction
    task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host_u.xfer(1'b0, a, d, q);
    endtask
    task automatic rd(input logic [4:0] a);
        host_u.xfer(1'b1, a, 8'h00, q);
    endtask
    // Write voice three control, let it settle, then compare its wave byte.
    task automatic look(input logic [7:0] ctrl, input logic [7:0] exp, input string what);
        wr(5'h12, ctrl);
        repeat (4) @(negedge clk_in);
        rd(5'h1B);
        chk(what, {12'h000, q}, {12'h000, exp});
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // A hang costs one mismatch and still ends through the same verdict.
    initial begin
        #(40000 * 8);
        failures++;
        wrap_up();
    end
    // Main sequence; pitch is zero from reset so the phase sits at zero for duty tests.
    initial begin
        p = 16'($urandom(69003));
        repeat (12) @(negedge clk_in);
        rst_n_in = 1'b1;
        chk("level after reset", level[0] | level[1] | level[2], 20'h00000);
        for (int i = 0; i < 3; i++) begin
            wr(5'h10, duty[i][7:0]);
            wr(5'h11, {4'($urandom), duty[i][11:8]});
            look(8'h40, exp_pulse(duty[i], 12'h000), "pulse");
        end
        for (int i = 0; i < 6; i++) begin
            look(hctl[i], hexp[i], "hold");
        end
        p = 16'h0100 + 16'($urandom_range(16'h3EFF));
        wr(5'h0E, p[7:0]);
        wr(5'h0F, p[15:8]);
        look(8'h20, 8'h00, "saw from zero");
        r1 = q;
        repeat (62) @(negedge clk_in);
        rd(5'h1B);
        chk("saw rate", 20'(q - r1 - saw_step(p, 64) <= 8'h01), 20'h1);
        wr(5'h13, 8'h00);
        wr(5'h14, 8'hF0);
        wr(5'h12, 8'h49);
        repeat (5000) @(negedge clk_in);
        rd(5'h1C);
        e1 = q;
        chk("attack level", 20'(e1 >= 8'h04 && e1 <= 8'h06), 20'h1);
        wr(5'h12, 8'h48);
        repeat (6000) @(negedge clk_in);
        rd(5'h1C);
        chk("release level", 20'(q < e1 && q + 8'h03 >= e1), 20'h1);
        // Voice one bytes and a gate pulse, then voice three locked to a running voice two.
        wr(5'h00, 8'($urandom));
        wr(5'h03, 8'($urandom));
        wr(5'h04, 8'h01);
        wr(5'h04, 8'h00);
        wr(5'h12, 8'h22);
        wr(5'h07, 8'h01);
        wr(5'h08, 8'h80);
        // Voice two's top bit rises after 256 steps; voice three restarts one edge later.
        repeat (300) @(negedge clk_in);
        rd(5'h1B);
        chk("lock restart", {12'h000, q}, {12'h000, saw_step(p, 43)});
        // Stopping after 384 fast steps leaves the source's top bit high for the ring check.
        repeat (80) @(negedge clk_in);
        wr(5'h08, 8'h00);
        look(8'h1C, 8'hFF, "ring");
        wr(5'h04, 8'h48);
        repeat (4) @(negedge clk_in);
        chk("ungated voice", level[0], 20'h00000);
        rd(5'h00);
        chk("write-only read", {12'h000, q}, 20'h00000);
        rd(5'h1F);
        chk("unmapped read", {12'h000, q}, 20'h00000);
        wrap_up();
    end
endmodule
